// ===== src/ctm_pkg.sv
// Package for the compact timer module: register map, fields, modes
package ctm_pkg;

  localparam int unsigned ADDR_W = 3;

  localparam logic [2:0] CTRL0_OFFSET    = 3'h0;
  localparam logic [2:0] CTRL1_OFFSET    = 3'h1;
  localparam logic [2:0] CNT_LOW_OFFSET  = 3'h2;
  localparam logic [2:0] CNT_HIGH_OFFSET = 3'h3;
  localparam logic [2:0] CMPA_LOW_OFFSET = 3'h4;
  localparam logic [2:0] CMPA_HIGH_OFFSET= 3'h5;

  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [9:0] CNT_RESET   = 10'h000;
  localparam logic [9:0] CMPA_RESET  = 10'h000;
  localparam logic [9:0] CNT_MAX     = 10'h3FF;

  localparam int unsigned CTRL0_PAUSE_BIT  = 7;
  localparam int unsigned CTRL0_CLK_LSB    = 4;
  localparam int unsigned CTRL0_ENABLE_BIT = 3;
  localparam int unsigned CTRL0_PERIOD_LSB = 0;
  localparam int unsigned CTRL1_MODE_LSB   = 6;
  localparam int unsigned CTRL1_ACTION_LSB = 4;
  localparam int unsigned CTRL1_INIT_BIT   = 3;
  localparam int unsigned CTRL1_POL_BIT    = 2;
  localparam int unsigned CTRL1_SWAP_BIT   = 1;
  localparam int unsigned CTRL1_CLR_BIT    = 0;

  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_PWM     = 2'h2;
  localparam logic [1:0] MODE_TIMER   = 2'h3;

  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  localparam logic [2:0] CLK_SYS_DIV4   = 3'h0;
  localparam logic [2:0] CLK_SYS        = 3'h1;
  localparam logic [2:0] CLK_HIGH_DIV16 = 3'h2;
  localparam logic [2:0] CLK_HIGH_DIV64 = 3'h3;
  localparam logic [2:0] CLK_SUB_A      = 3'h4;
  localparam logic [2:0] CLK_SUB_B      = 3'h5;
  localparam logic [2:0] CLK_EXT_RISE   = 3'h6;
  localparam logic [2:0] CLK_EXT_FALL   = 3'h7;

  localparam logic [5:0] DIV_SYS4   = 6'h03;
  localparam logic [5:0] DIV_HIGH16 = 6'h0F;
  localparam logic [5:0] DIV_HIGH64 = 6'h3F;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } ctm_bus_req_type;

  typedef struct packed {
    logic timer_output_pin;
    logic timer_output_inverted_pin;
    logic period_match_irq;
    logic compare_a_match_irq;
  } ctm_out_type;

endpackage : ctm_pkg

// ===== src/ctm_timer.sv
// Compact 10-bit timer: counter, two comparators, output logic, byte registers
`timescale 1ns/1ps
`default_nettype none
module ctm_timer (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire ctm_pkg::ctm_bus_req_type bus_req,
  output logic [7:0]                   rdata,
  input  wire logic                    high_clk,
  input  wire logic                    sub_clk,
  input  wire logic                    external_clock_pin,
  output ctm_pkg::ctm_out_type         pins
);
  import ctm_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [9:0] count;
    logic [9:0] cmpa;
    logic [7:0] low_buf;
    logic [7:0] rdata;
    logic [5:0] sys_div;
    logic [5:0] high_div;
    logic [2:0] high_sync;
    logic [2:0] sub_sync;
    logic [2:0] ext_sync;
    logic       out_level;
    logic       period_irq;
    logic       cmpa_irq;
  } ctm_state_type;

  ctm_state_type s_q;
  ctm_state_type s_d;

  // Edge of a synchronised level: sample 1 and 2 only, never stage 0
  function automatic logic rise_of(input logic [2:0] sync);
    rise_of = sync[1] & ~sync[2];
  endfunction : rise_of

  function automatic logic fall_of(input logic [2:0] sync);
    fall_of = ~sync[1] & sync[2];
  endfunction : fall_of

  logic       enable;
  logic       pause;
  logic [2:0] clk_sel;
  logic [2:0] period_bits;
  logic [1:0] mode;
  logic [1:0] action;
  logic       init_level;
  logic       polarity;
  logic       swap;
  logic       clear_sel;
  logic       tick;
  logic       high_tick;
  logic [2:0] period_top;
  logic       period_match;
  logic       cmpa_match;
  logic       overflow;
  logic       clear_match;
  logic       pwm_active;
  logic       raw_out;
  logic       enable_rise;
  logic [7:0] new_ctrl0;

  always_comb begin
    enable      = s_q.ctrl0[CTRL0_ENABLE_BIT];
    pause       = s_q.ctrl0[CTRL0_PAUSE_BIT];
    clk_sel     = s_q.ctrl0[CTRL0_CLK_LSB +: 3];
    period_bits = s_q.ctrl0[CTRL0_PERIOD_LSB +: 3];
    mode        = s_q.ctrl1[CTRL1_MODE_LSB +: 2];
    action      = s_q.ctrl1[CTRL1_ACTION_LSB +: 2];
    init_level  = s_q.ctrl1[CTRL1_INIT_BIT];
    polarity    = s_q.ctrl1[CTRL1_POL_BIT];
    swap        = s_q.ctrl1[CTRL1_SWAP_BIT];
    clear_sel   = s_q.ctrl1[CTRL1_CLR_BIT];
  end

  // Tick source select
  always_comb begin
    high_tick = rise_of(s_q.high_sync);
    unique case (clk_sel)
      CLK_SYS_DIV4:   tick = (s_q.sys_div[1:0] == DIV_SYS4[1:0]);
      CLK_SYS:        tick = 1'b1;
      CLK_HIGH_DIV16: tick = high_tick && (s_q.high_div[3:0] == DIV_HIGH16[3:0]);
      CLK_HIGH_DIV64: tick = high_tick && (s_q.high_div == DIV_HIGH64);
      CLK_SUB_A,
      CLK_SUB_B:      tick = rise_of(s_q.sub_sync);
      CLK_EXT_RISE:   tick = rise_of(s_q.ext_sync);
      CLK_EXT_FALL:   tick = fall_of(s_q.ext_sync);
    endcase
  end

  // Comparators
  always_comb begin
    period_top   = period_bits - 3'h1;
    // Match on the last count of a period: N gives N*128 ticks, zero wraps at 1023
    period_match = (s_q.count[6:0] == 7'h7F) && (s_q.count[9:7] == period_top);
    cmpa_match   = (s_q.count == s_q.cmpa);
    overflow     = (s_q.count == CNT_MAX);
    // Period zero lets the counter run to full range
    clear_match  = clear_sel ? cmpa_match : (period_match || overflow);
  end

  // PWM: duty comparator decides active phase; period one clears counter when clear_sel is 0, compare A when it is 1
  always_comb begin
    logic [9:0] duty;
    duty = swap ? {period_bits, 7'h00} : s_q.cmpa;
    pwm_active = (s_q.count < duty);
    unique case (action)
      ACT_NONE:   raw_out = ~init_level;
      ACT_LOW:    raw_out = init_level;
      ACT_HIGH:   raw_out = pwm_active ? init_level : ~init_level;
      ACT_TOGGLE: raw_out = ~init_level;
    endcase
  end

  always_comb begin
    logic       run_tick;
    s_d       = s_q;
    new_ctrl0 = s_q.ctrl0;
    run_tick  = 1'b0;

    s_d.high_sync = {s_q.high_sync[1:0], high_clk};
    s_d.sub_sync  = {s_q.sub_sync[1:0], sub_clk};
    s_d.ext_sync  = {s_q.ext_sync[1:0], external_clock_pin};
    s_d.sys_div   = s_q.sys_div + 6'h01;
    if (high_tick) begin
      s_d.high_div = s_q.high_div + 6'h01;
    end

    // Register writes
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        CTRL0_OFFSET:     new_ctrl0 = bus_req.wdata;
        CTRL1_OFFSET:     s_d.ctrl1 = bus_req.wdata;
        CMPA_LOW_OFFSET:  s_d.low_buf = bus_req.wdata;
        CMPA_HIGH_OFFSET: s_d.cmpa = {bus_req.wdata[1:0], s_q.low_buf};
        default: ;
      endcase
    end
    s_d.ctrl0   = new_ctrl0;
    enable_rise = new_ctrl0[CTRL0_ENABLE_BIT] && !enable;

    // Register reads, data one cycle later
    s_d.rdata = 8'h00;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        CTRL0_OFFSET:     s_d.rdata = s_q.ctrl0;
        CTRL1_OFFSET:     s_d.rdata = s_q.ctrl1;
        CNT_LOW_OFFSET,
        CMPA_LOW_OFFSET:  s_d.rdata = s_q.low_buf;
        CNT_HIGH_OFFSET: begin
          s_d.rdata   = {6'h00, s_q.count[9:8]};
          s_d.low_buf = s_q.count[7:0];
        end
        CMPA_HIGH_OFFSET: begin
          s_d.rdata   = {6'h00, s_q.cmpa[9:8]};
          s_d.low_buf = s_q.cmpa[7:0];
        end
        default:          s_d.rdata = 8'h00;
      endcase
    end

    // Interrupt pulses, one per comparator
    s_d.period_irq = 1'b0;
    s_d.cmpa_irq   = 1'b0;
    run_tick = enable && !pause && tick;

    if (enable_rise) begin
      s_d.count = CNT_RESET;
      if (mode == MODE_COMPARE) begin
        s_d.out_level = init_level;
      end
    end else if (run_tick) begin
      s_d.period_irq = period_match;
      s_d.cmpa_irq   = cmpa_match;
      if (clear_match) begin
        s_d.count = CNT_RESET;
      end else begin
        s_d.count = s_q.count + 10'h001;
      end
      if (mode == MODE_COMPARE && cmpa_match) begin
        unique case (action)
          ACT_NONE:   s_d.out_level = s_q.out_level;
          ACT_LOW:    s_d.out_level = 1'b0;
          ACT_HIGH:   s_d.out_level = 1'b1;
          ACT_TOGGLE: s_d.out_level = ~s_q.out_level;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q        <= '0;
      s_q.ctrl0  <= CTRL0_RESET;
      s_q.ctrl1  <= CTRL1_RESET;
      s_q.count  <= CNT_RESET;
      s_q.cmpa   <= CMPA_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Output pins; timer mode leaves the pin at zero, undefined mode too
  always_comb begin
    logic lvl;
    lvl = 1'b0;
    unique case (mode)
      MODE_COMPARE: lvl = s_q.out_level ^ polarity;
      MODE_PWM:     lvl = raw_out ^ polarity;
      default:      lvl = 1'b0;
    endcase
    pins.timer_output_pin          = lvl;
    pins.timer_output_inverted_pin = ~lvl;
    pins.period_match_irq          = s_q.period_irq;
    pins.compare_a_match_irq       = s_q.cmpa_irq;
    rdata                          = s_q.rdata;
  end

endmodule : ctm_timer
`default_nettype wire

// ===== verification/ctm_timer_sva.sv
// Port checker for the compact timer
`timescale 1ns/1ps
`default_nettype none
module ctm_timer_sva (
  input wire logic                     ref_clk,
  input wire logic                     rst,
  input wire ctm_pkg::ctm_bus_req_type bus_req,
  input wire logic [7:0]               rdata,
  input wire logic                     high_clk,
  input wire logic                     sub_clk,
  input wire logic                     external_clock_pin,
  input wire ctm_pkg::ctm_out_type     pins
);
  import ctm_pkg::*;
  logic [7:0] c0_q;
  logic [7:0] c1_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Shadow of the control bytes, every bit writable
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      c0_q <= CTRL0_RESET;
      c1_q <= CTRL1_RESET;
    end else if (bus_req.wr && bus_req.addr == CTRL0_OFFSET) begin
      c0_q <= bus_req.wdata;
    end else if (bus_req.wr && bus_req.addr == CTRL1_OFFSET) begin
      c1_q <= bus_req.wdata;
    end
  end
  inv_pin_a: assert property (pins.timer_output_inverted_pin != pins.timer_output_pin)
    else $error("inverted pin equals output pin");
  rdata_idle_a: assert property (!bus_req.rd |=> rdata == 8'h00)
    else $error("read data without read");
  high_bytes_a: assert property (bus_req.rd && bus_req.addr[0] && bus_req.addr[2:1] != 2'h0 |=> rdata[7:2] == 6'h00)
    else $error("high byte upper bits set");
  unmapped_a: assert property (bus_req.rd && bus_req.addr > CMPA_HIGH_OFFSET |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  ctrl0_read_a: assert property (bus_req.rd && bus_req.addr == CTRL0_OFFSET |=> rdata == c0_q)
    else $error("control 0 readback wrong");
  ctrl1_read_a: assert property (bus_req.rd && bus_req.addr == CTRL1_OFFSET |=> rdata == c1_q)
    else $error("control 1 readback wrong");
  reset_state_a: assert property (disable iff (1'b0) rst |=> rdata == 8'h00 && !pins.period_match_irq && !pins.compare_a_match_irq && !pins.timer_output_pin)
    else $error("outputs not cleared by reset");
  period_pulse_a: assert property (pins.period_match_irq |=> !pins.period_match_irq)
    else $error("period interrupt longer than one cycle");
  timer_pin_low_a: assert property (c1_q[7:6] == MODE_TIMER |-> !pins.timer_output_pin)
    else $error("output pin driven in timer mode");
endmodule : ctm_timer_sva
bind ctm_timer ctm_timer_sva i_sva (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req),
  .rdata(rdata), .high_clk(high_clk), .sub_clk(sub_clk),
  .external_clock_pin(external_clock_pin), .pins(pins));
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the compact timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ctm_pkg::*;
  localparam logic [7:0] C0S [4] = '{8'h18, 8'h08, 8'h19, 8'h18};
  localparam logic [7:0] C1S [4] = '{8'h01, 8'h01, 8'h00, 8'h00};
  localparam logic [15:0] GAPS [4] = '{16'h0124, 16'h0490, 16'h0080, 16'h0400};
  localparam logic [7:0] EXT [2] = '{8'h68, 8'h78};
  localparam logic [7:0] CLKS [2] = '{8'h28, 8'h48};
  localparam logic [15:0] CGAPS [2] = '{16'h0420, 16'h0042};
  logic            ref_clk;
  logic            rst;
  ctm_bus_req_type req;
  logic [7:0]      rdata;
  logic            high_clk;
  logic            ext_pin;
  ctm_out_type     pins;
  int              errors;
  int              compares;
  int              cyc;
  int              n;
  ctm_timer i_dut (.ref_clk(ref_clk), .rst(rst), .bus_req(req), .rdata(rdata),
    .high_clk(high_clk), .sub_clk(high_clk), .external_clock_pin(ext_pin), .pins(pins));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    high_clk <= rst ? 1'b0 : ~high_clk;
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] v);
    compares++;
    if (v !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, v);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge ref_clk);
    req.wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    chk("rdata", {8'h00, e}, {8'h00, rdata});
    @(posedge ref_clk);
  endtask : rd
  // Waits for the next pulse; bounded so a dead timer cannot hang
  task automatic wirq(input logic p, output int g);
    g = 0;
    do begin
      @(posedge ref_clk);
      #1;
      g++;
    end while (!(p ? pins.period_match_irq : pins.compare_a_match_irq) && g < 3000);
    @(posedge ref_clk);
  endtask : wirq
  task automatic pin(input logic e);
    #1;
    chk("pins", {14'h0, ~e, e}, {14'h0, pins.timer_output_inverted_pin, pins.timer_output_pin});
    @(posedge ref_clk);
  endtask : pin
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    rst = 1'b1;
    req = '0;
    ext_pin = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    $display("reset and map test done");
    wr(CMPA_LOW_OFFSET, 8'h14);
    wr(CMPA_HIGH_OFFSET, 8'h00);
    wr(CMPA_LOW_OFFSET, 8'h23);
    rd(CMPA_HIGH_OFFSET, 8'h00);
    rd(CMPA_LOW_OFFSET, 8'h14);
    wr(CMPA_LOW_OFFSET, 8'h23);
    wr(CMPA_HIGH_OFFSET, 8'h01);
    rd(CMPA_HIGH_OFFSET, 8'h01);
    rd(CMPA_LOW_OFFSET, 8'h23);
    $display("compare pair test done");
    foreach (C0S[i]) begin
      wr(CTRL0_OFFSET, 8'h00);
      wr(CTRL1_OFFSET, C1S[i]);
      wr(CTRL0_OFFSET, C0S[i]);
      wirq(C1S[i] == 8'h00, n);
      wirq(C1S[i] == 8'h00, n);
      chk("irq gap", GAPS[i], 16'(n + 1));
    end
    $display("period and clear test done");
    for (int i = 1; i < 4; i++) begin
      wr(CTRL0_OFFSET, 8'h00);
      wr(CTRL1_OFFSET, {2'h0, i[1:0], i == 1, 3'h1});
      wr(CTRL0_OFFSET, 8'h18);
      pin(i == 1);
      wirq(1'b0, n);
      pin(i != 1);
      if (i == 3) begin
        wirq(1'b0, n);
        pin(1'b0);
      end
    end
    rd(CTRL1_OFFSET, 8'h31);
    $display("output action test done");
    foreach (EXT[j]) begin
      wr(CTRL0_OFFSET, 8'h00);
      wr(CTRL0_OFFSET, EXT[j]);
      repeat (5) begin
        repeat (4) @(posedge ref_clk);
        ext_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        ext_pin <= 1'b0;
      end
      repeat (6) @(posedge ref_clk);
      wr(CNT_LOW_OFFSET, 8'hFF);
      wr(CNT_HIGH_OFFSET, 8'hFF);
      rd(CNT_HIGH_OFFSET, 8'h00);
      rd(CNT_LOW_OFFSET, 8'h05);
    end
    $display("external clock test done");
    for (int p = 0; p < 2; p++) begin
      wr(CTRL0_OFFSET, 8'h00);
      wr(CMPA_LOW_OFFSET, 8'h20);
      wr(CMPA_HIGH_OFFSET, 8'h00);
      wr(CTRL1_OFFSET, p[0] ? 8'hAC : 8'hA8);
      wr(CTRL0_OFFSET, 8'h19);
      wirq(1'b1, n);
      n = 0;
      // One full 128-tick period; high count equals the duty value, or 128 minus it when the polarity bit inverts
      repeat (128) begin
        #1;
        if (pins.timer_output_pin === 1'b1) begin
          n++;
        end
        @(posedge ref_clk);
      end
      chk("pwm high cycles", p[0] ? 16'h0060 : 16'h0020, 16'(n));
    end
    wr(CTRL0_OFFSET, 8'h00);
    wr(CTRL1_OFFSET, 8'hC0);
    wr(CTRL0_OFFSET, 8'h18);
    pin(1'b0);
    foreach (CLKS[k]) begin
      wr(CTRL0_OFFSET, 8'h00);
      wr(CTRL1_OFFSET, 8'h01);
      wr(CTRL0_OFFSET, CLKS[k]);
      wirq(1'b0, n);
      wirq(1'b0, n);
      chk("clock gap", CGAPS[k], 16'(n + 1));
    end
    wr(CTRL0_OFFSET, 8'h00);
    wr(CTRL0_OFFSET, 8'h18);
    wr(CTRL0_OFFSET, 8'h98);
    repeat (20) @(posedge ref_clk);
    rd(CNT_HIGH_OFFSET, 8'h00);
    rd(CNT_LOW_OFFSET, 8'h02);
    $display("pwm, clock and pause test done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
